// ### dv/pecirq_pins.sv
`timescale 1ns/1ps
`default_nettype none
module pecirq_pins (
  input wire logic pclk,
  output logic [7:0] porta_pin,
  output logic [7:0] portb_pin,
  output logic [7:0] portc_pin
);
  initial begin
    porta_pin = 8'h00;
    portb_pin = 8'h00;
    portc_pin = 8'h00;
  end
  // level held four clocks: two sync stages, compare and flag on the third, then settled for the bench
  task automatic drive(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] c);
    @(posedge pclk);
    porta_pin <= a;
    portb_pin <= b;
    portc_pin <= c;
    repeat (4) @(posedge pclk);
  endtask : drive
endmodule : pecirq_pins
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic core_sleeping = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, change_irq, wake_req, men;
  logic [7:0] pa, pb, pc;
  logic [7:0] rise [3], fall [3], flg [3], prv [3], nw [3];
  int err_count = 0;
  int check_count = 0;
  int seed = 86210;
  localparam logic [11:0] BASE [3] = '{pecirq_pkg::OFF_PA_RISE,
      pecirq_pkg::OFF_PB_RISE, pecirq_pkg::OFF_PC_RISE};
  localparam logic [7:0] MK [3] = '{pecirq_pkg::PA_MASK,
      pecirq_pkg::PB_MASK, pecirq_pkg::PC_MASK};
  always #10 pclk = ~pclk;
  pecirq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .porta_pin(pa), .portb_pin(pb), .portc_pin(pc),
    .core_sleeping(core_sleeping), .change_irq(change_irq),
    .wake_req(wake_req));
  pecirq_pins pins_u (.pclk(pclk), .porta_pin(pa), .portb_pin(pb),
    .portc_pin(pc));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
    r = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [7:0] hits(input int i);
    return ((nw[i] & ~prv[i] & rise[i]) | (~nw[i] & prv[i] & fall[i]))
        & MK[i];
  endfunction : hits
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h24; a += 4) begin
      apb(1'b0, a[11:0], 8'h00, rd);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h100, 8'h00, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, BASE[i] + 12'(4 * k), 8'hff, rd);
        apb(1'b0, BASE[i] + 12'(4 * k), 8'h00, rd);
        chk("mask", {24'h0, MK[i]}, rd);
        apb(1'b1, BASE[i] + 12'(4 * k), 8'h00, rd);
        apb(1'b0, BASE[i] + 12'(4 * k), 8'h00, rd);
        chk("clear", 32'h0, rd);
      end
      prv[i] = 8'h00;
      flg[i] = 8'h00;
    end
    $display("test registers done");
    for (int n = 0; n < 24; n++) begin
      men = (n < 2) ? 1'b0 : 1'($random(seed));
      apb(1'b1, pecirq_pkg::OFF_CTRL, {7'h0, men}, rd);
      core_sleeping <= 1'($random(seed));
      for (int i = 0; i < 3; i++) begin
        rise[i] = (n < 2) ? 8'hff : 8'($random(seed));
        fall[i] = (n < 2) ? 8'hff : 8'($random(seed));
        nw[i] = (n < 2) ? ~prv[i] : 8'($random(seed));
        apb(1'b1, BASE[i], rise[i], rd);
        apb(1'b1, BASE[i] + 12'h004, fall[i], rd);
      end
      pins_u.drive(nw[0], nw[1], nw[2]);
      for (int i = 0; i < 3; i++) begin
        flg[i] = flg[i] | hits(i);
        prv[i] = nw[i];
      end
      rd = {31'h0, men & |{flg[0], flg[1], flg[2]}};
      chk("change_irq", rd, {31'h0, change_irq});
      chk("wake_req", rd & core_sleeping, {31'h0, wake_req});
      apb(1'b0, pecirq_pkg::OFF_CTRL, 8'h00, rd);
      chk("control", {29'h0, core_sleeping, |{flg[0], flg[1], flg[2]},
          men}, rd);
      for (int i = 0; i < 3; i++) begin
        apb(1'b0, BASE[i] + 12'h008, 8'h00, rd);
        chk("flags", {24'h0, flg[i]}, rd);
        if (n % 2 == 1) begin
          apb(1'b1, BASE[i] + 12'h008, (rd[7:0] ^ 8'hff) & rd[7:0],
              rd);
          flg[i] = 8'h00;
        end
      end
    end
    $display("test random edges done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// ### rtl/pecirq_pkg.sv
package pecirq_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_PA_RISE = 12'h000;
  localparam logic [11:0] OFF_PA_FALL = 12'h004;
  localparam logic [11:0] OFF_PA_FLAG = 12'h008;
  localparam logic [11:0] OFF_PB_RISE = 12'h00c;
  localparam logic [11:0] OFF_PB_FALL = 12'h010;
  localparam logic [11:0] OFF_PB_FLAG = 12'h014;
  localparam logic [11:0] OFF_PC_RISE = 12'h018;
  localparam logic [11:0] OFF_PC_FALL = 12'h01c;
  localparam logic [11:0] OFF_PC_FLAG = 12'h020;
  localparam logic [11:0] OFF_CTRL = 12'h024;
  // implemented-bit masks
  localparam logic [7:0] PA_MASK = 8'h3f;
  localparam logic [7:0] PB_MASK = 8'hf0;
  localparam logic [7:0] PC_MASK = 8'hff;
  // control register fields
  localparam int CTRL_MEN_BIT = 0;
  localparam int CTRL_SUM_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam logic [7:0] RESET_VAL = 8'h00;
endpackage : pecirq_pkg

// ### rtl/pecirq_top.sv
// Functional notes
// RULE1: with master enable set, enabled edge raises interrupt and wakes sleeping core.
// RULE2: edges during sleep are recorded in flags before wake is signalled.
// RULE3: port A rising enable bits 5:0, one per pin.
// RULE4: port A falling enable bits 5:0, one per pin.
// RULE5: port A flag set by enabled rising or falling edge on its pin.
// RULE6: flag reads zero until enabled edge; software clears by writing zero.
// RULE7: port A bits 7:6 unimplemented, read zero.
// RULE8: port B rising enable bits 7:4; low nibble reads zero.
// RULE9: port B falling enable bits 7:4.
// RULE10: port B flag bits 7:4 set by enabled edges.
// RULE11: port C rising enable bits 7:0.
// RULE12: port C falling enable bits 7:0.
// RULE13: all enable and flag bits reset to zero.
// RULE14: flags software read/write and hardware settable independently.
// RULE15: software should clear flags by xor-and sequence of known set bits.
// RULE16: edge detection and flag setting continue with master enable clear.
// RULE17: summary flag is set while any per-pin flag is set.
// RULE18: edge during a clearing write leaves the flag set.
// RULE19: both enables set detect either edge polarity.
// RULE20: pins synchronised, previous sample compared, one pulse per edge.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pecirq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] porta_pin,
  input wire logic [7:0] portb_pin,
  input wire logic [7:0] portc_pin,
  input wire logic core_sleeping,
  output logic change_irq,
  output logic wake_req
);
  typedef struct packed {
    logic [7:0] a_s1;
    logic [7:0] a_s2;
    logic [7:0] a_prev;
    logic [7:0] b_s1;
    logic [7:0] b_s2;
    logic [7:0] b_prev;
    logic [7:0] c_s1;
    logic [7:0] c_s2;
    logic [7:0] c_prev;
    logic [7:0] a_rise;
    logic [7:0] a_fall;
    logic [7:0] a_flag;
    logic [7:0] b_rise;
    logic [7:0] b_fall;
    logic [7:0] b_flag;
    logic [7:0] c_rise;
    logic [7:0] c_fall;
    logic [7:0] c_flag;
    logic master_en;
    logic [31:0] rdata;
    logic irq;
    logic wake;
  } pecirq_state_t;

  pecirq_state_t st_reg;
  pecirq_state_t st_next;

  logic [7:0] a_hit;
  logic [7:0] b_hit;
  logic [7:0] c_hit;
  logic wr_acc;
  logic rd_acc;
  logic any_flag;

  // enabled-edge hits for one port, limited to implemented pins
  function automatic logic [7:0] edge_hit(input logic [7:0] cur,
      input logic [7:0] prv, input logic [7:0] rise,
      input logic [7:0] fall, input logic [7:0] mask);
    edge_hit = ((cur & ~prv & rise) | (~cur & prv & fall)) & mask;
  endfunction : edge_hit

  // flag update: write value for lane, then hardware set wins
  function automatic logic [7:0] flag_upd(input logic [7:0] cur,
      input logic wr, input logic [7:0] wval, input logic [7:0] hit,
      input logic [7:0] mask);
    logic [7:0] v;
    v = wr ? (wval & mask) : cur;
    flag_upd = v | hit;
  endfunction : flag_upd

  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_reg.rdata;
  assign change_irq = st_reg.irq;
  assign wake_req = st_reg.wake;

  always_comb begin
    st_next = st_reg;
    // two-stage sync, then compare against previous sample
    st_next.a_s1 = porta_pin;
    st_next.a_s2 = st_reg.a_s1;
    st_next.a_prev = st_reg.a_s2;
    st_next.b_s1 = portb_pin;
    st_next.b_s2 = st_reg.b_s1;
    st_next.b_prev = st_reg.b_s2;
    st_next.c_s1 = portc_pin;
    st_next.c_s2 = st_reg.c_s1;
    st_next.c_prev = st_reg.c_s2;
    a_hit = edge_hit(st_reg.a_s2, st_reg.a_prev, st_reg.a_rise,
        st_reg.a_fall, pecirq_pkg::PA_MASK); // [RULE3] [RULE4] [RULE20]
    b_hit = edge_hit(st_reg.b_s2, st_reg.b_prev, st_reg.b_rise,
        st_reg.b_fall, pecirq_pkg::PB_MASK); // [RULE8] [RULE9] [RULE19]
    c_hit = edge_hit(st_reg.c_s2, st_reg.c_prev, st_reg.c_rise,
        st_reg.c_fall, pecirq_pkg::PC_MASK); // [RULE11] [RULE12]
    if (wr_acc) begin
      case (paddr)
        pecirq_pkg::OFF_PA_RISE: begin
          st_next.a_rise = pwdata[7:0] & pecirq_pkg::PA_MASK; // [RULE7]
        end
        pecirq_pkg::OFF_PA_FALL: begin
          st_next.a_fall = pwdata[7:0] & pecirq_pkg::PA_MASK; // [RULE7]
        end
        pecirq_pkg::OFF_PB_RISE: begin
          st_next.b_rise = pwdata[7:0] & pecirq_pkg::PB_MASK; // [RULE8]
        end
        pecirq_pkg::OFF_PB_FALL: begin
          st_next.b_fall = pwdata[7:0] & pecirq_pkg::PB_MASK;
        end
        pecirq_pkg::OFF_PC_RISE: begin
          st_next.c_rise = pwdata[7:0];
        end
        pecirq_pkg::OFF_PC_FALL: begin
          st_next.c_fall = pwdata[7:0];
        end
        pecirq_pkg::OFF_CTRL: begin
          st_next.master_en = pwdata[pecirq_pkg::CTRL_MEN_BIT];
        end
        default: begin
        end
      endcase
    end
    // flags: hardware set wins over software write [RULE14] [RULE18]
    st_next.a_flag = flag_upd(st_reg.a_flag,
        wr_acc && paddr == pecirq_pkg::OFF_PA_FLAG, pwdata[7:0], a_hit,
        pecirq_pkg::PA_MASK); // [RULE5] [RULE6] [RULE16]
    st_next.b_flag = flag_upd(st_reg.b_flag,
        wr_acc && paddr == pecirq_pkg::OFF_PB_FLAG, pwdata[7:0], b_hit,
        pecirq_pkg::PB_MASK); // [RULE10]
    st_next.c_flag = flag_upd(st_reg.c_flag,
        wr_acc && paddr == pecirq_pkg::OFF_PC_FLAG, pwdata[7:0], c_hit,
        pecirq_pkg::PC_MASK);
    any_flag = |{st_next.a_flag, st_next.b_flag, st_next.c_flag};
    // irq/wake follow the flags registered this same edge [RULE2]
    st_next.irq = any_flag && st_next.master_en; // [RULE1] [RULE16]
    st_next.wake = any_flag && st_next.master_en && core_sleeping; // [RULE1]
    st_next.rdata = st_reg.rdata;
    if (rd_acc) begin
      st_next.rdata = 32'h0000_0000;
      case (paddr)
        pecirq_pkg::OFF_PA_RISE: st_next.rdata[7:0] = st_reg.a_rise;
        pecirq_pkg::OFF_PA_FALL: st_next.rdata[7:0] = st_reg.a_fall;
        pecirq_pkg::OFF_PA_FLAG: st_next.rdata[7:0] = st_reg.a_flag;
        pecirq_pkg::OFF_PB_RISE: st_next.rdata[7:0] = st_reg.b_rise;
        pecirq_pkg::OFF_PB_FALL: st_next.rdata[7:0] = st_reg.b_fall;
        pecirq_pkg::OFF_PB_FLAG: st_next.rdata[7:0] = st_reg.b_flag;
        pecirq_pkg::OFF_PC_RISE: st_next.rdata[7:0] = st_reg.c_rise;
        pecirq_pkg::OFF_PC_FALL: st_next.rdata[7:0] = st_reg.c_fall;
        pecirq_pkg::OFF_PC_FLAG: st_next.rdata[7:0] = st_reg.c_flag;
        pecirq_pkg::OFF_CTRL: begin
          st_next.rdata[pecirq_pkg::CTRL_MEN_BIT] = st_reg.master_en;
          // summary of all per-pin flags [RULE17]
          st_next.rdata[pecirq_pkg::CTRL_SUM_BIT] =
              |{st_reg.a_flag, st_reg.b_flag, st_reg.c_flag};
          st_next.rdata[pecirq_pkg::CTRL_SLEEP_BIT] = core_sleeping;
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0; // [RULE13]
    end else begin
      st_reg <= st_next;
    end
  end

  logic sum_now;
  assign sum_now = |{st_reg.a_flag, st_reg.b_flag, st_reg.c_flag};
  logic ctrl_wr;
  assign ctrl_wr = wr_acc && paddr == pecirq_pkg::OFF_CTRL;

  // enabled edge seen by the compare stage of one pin
  sequence s_a_rise(int i);
    st_reg.a_rise[i] && st_reg.a_s2[i] && !st_reg.a_prev[i];
  endsequence

  sequence s_a_fall(int i);
    st_reg.a_fall[i] && !st_reg.a_s2[i] && st_reg.a_prev[i];
  endsequence

  sequence s_b_fall(int i);
    st_reg.b_fall[i] && !st_reg.b_s2[i] && st_reg.b_prev[i];
  endsequence

  sequence s_b_rise(int i);
    st_reg.b_rise[i] && st_reg.b_s2[i] && !st_reg.b_prev[i];
  endsequence

  sequence s_c_rise(int i);
    st_reg.c_rise[i] && st_reg.c_s2[i] && !st_reg.c_prev[i];
  endsequence

  sequence s_c_fall(int i);
    st_reg.c_fall[i] && !st_reg.c_s2[i] && st_reg.c_prev[i];
  endsequence

  sequence s_c_any(int i);
    st_reg.c_fall[i] && st_reg.c_rise[i] &&
        (st_reg.c_s2[i] != st_reg.c_prev[i]);
  endsequence

  chk_a_rise_flag: assert property ( // [RULE5]
    @(posedge pclk) disable iff (!presetn)
    s_a_rise(0) |=> st_reg.a_flag[0])
    else $error("port a rise did not set flag");

  chk_a_fall_flag: assert property ( // [RULE4]
    @(posedge pclk) disable iff (!presetn)
    s_a_fall(5) |=> st_reg.a_flag[5])
    else $error("port a fall did not set flag");

  chk_b_fall_flag: assert property ( // [RULE10]
    @(posedge pclk) disable iff (!presetn)
    s_b_fall(4) |=> st_reg.b_flag[4])
    else $error("port b fall did not set flag");

  chk_b_rise_flag: assert property ( // [RULE8]
    @(posedge pclk) disable iff (!presetn)
    s_b_rise(7) |=> st_reg.b_flag[7])
    else $error("port b rise did not set flag");

  chk_c_rise_flag: assert property ( // [RULE11]
    @(posedge pclk) disable iff (!presetn)
    s_c_rise(0) |=> st_reg.c_flag[0])
    else $error("port c rise did not set flag");

  chk_c_fall_flag: assert property ( // [RULE12]
    @(posedge pclk) disable iff (!presetn)
    s_c_fall(1) |=> st_reg.c_flag[1])
    else $error("port c fall did not set flag");

  chk_c_edge_flag: assert property ( // [RULE19]
    @(posedge pclk) disable iff (!presetn)
    s_c_any(7) |=> st_reg.c_flag[7])
    else $error("port c edge missed");

  chk_unimpl_zero: assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
    ((st_reg.a_flag | st_reg.a_rise | st_reg.a_fall) &
        ~pecirq_pkg::PA_MASK) == 8'h00 &&
    ((st_reg.b_flag | st_reg.b_rise | st_reg.b_fall) &
        ~pecirq_pkg::PB_MASK) == 8'h00)
    else $error("unimplemented bits set");

  chk_upper_read: assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
    rd_acc |=> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  chk_irq_follow: assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn)
    change_irq == (sum_now && st_reg.master_en))
    else $error("irq mismatch");

  chk_wake_irq: assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn)
    wake_req |-> change_irq)
    else $error("wake without interrupt");

  chk_set_beats_clr: assert property ( // [RULE18]
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == pecirq_pkg::OFF_PA_FLAG && a_hit[1])
      |=> st_reg.a_flag[1])
    else $error("edge lost during clear");

  chk_flag_no_men: assert property ( // [RULE16]
    @(posedge pclk) disable iff (!presetn)
    (!st_reg.master_en && !ctrl_wr && a_hit[2])
      |=> st_reg.a_flag[2] && !change_irq)
    else $error("flag not set with master off");

  chk_wake_sleep: assert property ( // [RULE2]
    @(posedge pclk) disable iff (!presetn)
    $rose(wake_req) |-> sum_now && $past(core_sleeping))
    else $error("wake without recorded flag");

  chk_sw_clear: assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == pecirq_pkg::OFF_PC_FLAG && pwdata[3] == 1'b0
      && !c_hit[3]) |=> !st_reg.c_flag[3])
    else $error("software clear failed");

  // steady port A pins must never produce a hit
  chk_hit_pulse: assert property ( // [RULE20]
    @(posedge pclk) disable iff (!presetn)
    (st_reg.a_s2 == st_reg.a_prev) |-> a_hit == 8'h00)
    else $error("hit without pin change");

  chk_no_enable: assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn)
    (st_reg.a_rise == 8'h00 && st_reg.a_fall == 8'h00)
      |-> a_hit == 8'h00)
    else $error("hit with edges disabled");

  chk_sum_read: assert property ( // [RULE17]
    @(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == pecirq_pkg::OFF_CTRL)
      |=> prdata[pecirq_pkg::CTRL_SUM_BIT] == $past(sum_now))
    else $error("summary flag read wrong");

  // state seen one edge after reset was applied
  chk_reset_zero: assert property ( // [RULE13]
    @(posedge pclk)
    !presetn |=> st_reg.a_flag == 8'h00 && st_reg.b_flag == 8'h00 &&
      st_reg.c_flag == 8'h00 && st_reg.a_rise == 8'h00 &&
      st_reg.c_fall == 8'h00 && !change_irq && !wake_req)
    else $error("state not cleared by reset");
endmodule : pecirq_top
`default_nettype wire
